/* File: core/asp_pkg.sv */
`default_nettype none
package asp_pkg;
  // Register addresses on the CPU memory port.
  localparam logic [15:0] ADDR_MODE   = 16'hff70;
  localparam logic [15:0] ADDR_STATUS = 16'hff71;
  localparam logic [15:0] ADDR_CLKD   = 16'hff72;
  localparam logic [15:0] ADDR_BAUD   = 16'hff73;
  localparam logic [15:0] ADDR_TXD    = 16'hff74;
  localparam logic [15:0] ADDR_RXD    = 16'hff75;

  // Reset values.
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] CLKD_RST   = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] RXBUF_RST  = 8'h00;

  // Writable bits; all others read as zero.
  localparam logic [7:0] MODE_MASK = 8'hfc;
  localparam logic [7:0] CLKD_MASK = 8'h86;
  localparam logic [7:0] BAUD_MASK = 8'hf0;

  // Field positions.
  localparam int MODE_TXE  = 7;
  localparam int MODE_RXE  = 6;
  localparam int MODE_PHI  = 5;
  localparam int MODE_PLO  = 4;
  localparam int MODE_CL   = 3;
  localparam int MODE_SL   = 2;
  localparam int CLKD_EN   = 7;
  localparam int CLKD_DIR  = 2;
  localparam int CLKD_CSCK = 1;
  localparam int STAT_PE   = 2;
  localparam int STAT_FE   = 1;
  localparam int STAT_OVE  = 0;
  localparam int BAUD_LSB  = 4;

  // Parity field encodings.
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // One bit lasts 16 source ticks; half a bit is one lap of a 3-bit count.
  localparam logic [3:0] BIT_LAST  = 4'hf;
  localparam logic [2:0] HALF_LAST = 3'h7;

  function automatic logic asp_ones_odd(input logic [7:0] d,
                                        input logic       char8);
    return ^(char8 ? d : {1'b0, d[6:0]});
  endfunction

  function automatic logic asp_tx_parity(input logic [7:0] d,
                                         input logic       char8,
                                         input logic [1:0] mode);
    logic odd;
    odd = asp_ones_odd(d, char8);
    return (mode == PAR_ODD) ? !odd : (mode == PAR_EVEN) ? odd : 1'b0;
  endfunction

  function automatic logic asp_rx_par_err(input logic [7:0] d,
                                          input logic       char8,
                                          input logic [1:0] mode,
                                          input logic       p);
    logic odd;
    odd = asp_ones_odd(d, char8) ^ p;
    return (mode == PAR_ODD) ? !odd : (mode == PAR_EVEN) ? odd : 1'b0;
  endfunction
endpackage
`default_nettype wire

/* File: core/asp_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_baud_gen (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Control
  input  wire logic [3:0] sel,
  input  wire logic       run,
  // Source tick, one cycle every 2^(sel+1) clocks for sel 0 to 7; none while sel[3] is set
  output logic            src_tick
);
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic       next_tick;
  logic [7:0] mask;

  // Codes with the top bit set select an external clock, which has no pin
  // here, so they stop the tick instead.
  always_comb begin
    mask = 8'hff >> (3'h7 - sel[2:0]);
    next_div_cnt = run ? div_cnt + 8'h01 : 8'h00;
    next_tick = run && !sel[3] && ((div_cnt & mask) == mask);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_cnt  <= 8'h00;
      src_tick <= 1'b0;
    end else begin
      div_cnt  <= next_div_cnt;
      src_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

/* File: core/asp_uart_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_uart_tx (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Timing
  input  wire logic       src_tick,
  // Control
  input  wire logic       enable,
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic       char8,
  input  wire logic [1:0] parity,
  input  wire logic       stop2,
  // Line and status
  output logic            line,
  output logic            busy,
  output logic            done
);
  logic [11:0] frame;
  logic [11:0] next_frame;
  logic [3:0]  bits_left;
  logic [3:0]  next_bits_left;
  logic [3:0]  sub;
  logic [3:0]  next_sub;
  logic        next_busy;
  logic        next_done;
  logic [10:0] body;
  logic [3:0]  pos;

  always_comb begin
    next_frame = frame;
    next_bits_left = bits_left;
    next_sub = sub;
    next_busy = busy;
    next_done = 1'b0;
    body = char8 ? {3'h7, data} : {4'hf, data[6:0]};
    pos = char8 ? 4'h8 : 4'h7;
    if (parity != asp_pkg::PAR_NONE) begin
      body[pos] = asp_pkg::asp_tx_parity(data, char8, parity);
      pos = pos + 4'h1;
    end
    if (!enable) begin
      next_busy = 1'b0;
      next_frame = 12'hfff;
    end else if (!busy) begin
      if (start) begin
        next_frame = {body, 1'b0};
        next_bits_left = pos + (stop2 ? 4'h2 : 4'h1);
        next_sub = 4'h0;
        next_busy = 1'b1;
      end
    end else if (src_tick) begin
      if (sub == asp_pkg::BIT_LAST) begin
        next_sub = 4'h0;
        next_frame = {1'b1, frame[11:1]};
        if (bits_left == 4'h0) begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_frame = 12'hfff;
        end else begin
          next_bits_left = bits_left - 4'h1;
        end
      end else begin
        next_sub = sub + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frame     <= 12'hfff;
      bits_left <= 4'h0;
      sub       <= 4'h0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      frame     <= next_frame;
      bits_left <= next_bits_left;
      sub       <= next_sub;
      busy      <= next_busy;
      done      <= next_done;
    end
  end

  assign line = frame[0];
endmodule
`default_nettype wire

/* File: core/asp_uart.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Odd mode sends parity making ones odd.
// - Odd mode flags error on even count.
// - Zero mode sends 0, never checks.
// - No-parity mode sends and expects no parity.
// - Writing transmit data starts a framed transfer.
// - Shift-out end raises transmit-complete event.
// - Receive enable starts sampling the input.
// - Low line confirmed at half bit.
// - Frame ends after data, parity, stop.
// - Frame end fills buffer, raises receive event.
// - Erroneous frames still fill buffer, interrupt.
// - Mid-frame disable aborts with nothing changed.
// - Late disable may update buffer only.
// - Parity, framing, overrun flags set per frame.
// - Buffer read or next frame clears status.
// - Clocked-mode register layout, resets to zero.
// - Mode register layout, resets to zero.
// - Parity, length and stop encodings decoded.
// - Even mode flags error on odd count.
// - Seven-bit mode drops and zeroes bit 7.
// - Receiver checks a single stop bit.
module asp_uart (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // CPU memory port
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic [7:0]       bus_rdata,
  // Serial pins
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  // Events
  input  wire logic        tx_req_clear,
  output logic             tx_complete_irq,
  output logic             tx_complete_request_flag,
  output logic             rx_complete_irq
);
  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PAR,
    RX_STOP,
    RX_DONE
  } asp_rx_state_t;

  // Register group.
  logic [7:0]    async_mode_control;
  logic [7:0]    next_async_mode_control;
  logic [7:0]    clocked_serial_mode_control;
  logic [7:0]    next_clocked_serial_mode_control;
  logic [7:0]    baud_gen_control;
  logic [7:0]    next_baud_gen_control;
  logic [7:0]    rx_error_status;
  logic [7:0]    next_rx_error_status;
  logic [7:0]    rx_buffer_reg;
  logic [7:0]    next_rx_buffer_reg;
  logic          rx_unread;
  logic          next_rx_unread;
  logic          next_tx_req;
  logic          next_rx_irq;
  logic [7:0]    next_bus_rdata;

  // Receiver group.
  asp_rx_state_t rx_state;
  asp_rx_state_t next_rx_state;
  logic [3:0]    rx_cnt;
  logic [3:0]    next_rx_cnt;
  logic [2:0]    rx_idx;
  logic [2:0]    next_rx_idx;
  logic [7:0]    rx_shift;
  logic [7:0]    next_rx_shift;
  logic          rx_par;
  logic          next_rx_par;
  logic [2:0]    rx_pend;
  logic [2:0]    next_rx_pend;
  logic          rx_copy;
  logic          rx_commit;

  // Input synchroniser group.
  logic          sync_a;
  logic          sync_b;
  logic          sync_c;
  logic          rx_line;
  logic          next_rx_line;

  // Decoded mode fields and links to the submodules.
  logic          tx_enable;
  logic          rx_enable;
  logic [1:0]    parity_mode;
  logic          char8;
  logic          stop2;
  logic          src_tick;
  logic          tx_start;
  logic          tx_busy;
  logic          tx_done;
  logic [2:0]    last_idx;

  always_comb begin
    tx_enable   = async_mode_control[asp_pkg::MODE_TXE];
    rx_enable   = async_mode_control[asp_pkg::MODE_RXE];
    parity_mode = {async_mode_control[asp_pkg::MODE_PHI],
                   async_mode_control[asp_pkg::MODE_PLO]};
    char8       = async_mode_control[asp_pkg::MODE_CL];
    stop2       = async_mode_control[asp_pkg::MODE_SL];
    last_idx    = char8 ? 3'h7 : 3'h6;
  end

  // A write while a frame is going out is dropped, since the shifter has
  // no holding stage behind it.
  assign tx_start = bus_wr && (bus_addr == asp_pkg::ADDR_TXD) &&
                    tx_enable && !tx_busy;

  asp_baud_gen u_baud (
    .core_clk (core_clk),
    .srst     (srst),
    .sel      (baud_gen_control[asp_pkg::BAUD_LSB +: 4]),
    .run      (tx_enable || rx_enable),
    .src_tick (src_tick)
  );

  asp_uart_tx u_tx (
    .core_clk (core_clk),
    .srst     (srst),
    .src_tick (src_tick),
    .enable   (tx_enable),
    .start    (tx_start),
    .data     (bus_wdata),
    .char8    (char8),
    .parity   (parity_mode),
    .stop2    (stop2),
    .line     (serial_out_pin),
    .busy     (tx_busy),
    .done     (tx_done)
  );

  // The pin is asynchronous; a level counts once two later stages agree.
  always_comb begin
    next_rx_line = (sync_b == sync_c) ? sync_c : rx_line;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync_a  <= 1'b1;
      sync_b  <= 1'b1;
      sync_c  <= 1'b1;
      rx_line <= 1'b1;
    end else begin
      sync_a  <= serial_in_pin;
      sync_b  <= sync_a;
      sync_c  <= sync_b;
      rx_line <= next_rx_line;
    end
  end

  // Receiver. The buffer is loaded at the stop sample, and the event and
  // status follow one tick later, which is the window in which a late
  // disable leaves a renewed buffer without an event.
  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt   = rx_cnt;
    next_rx_idx   = rx_idx;
    next_rx_shift = rx_shift;
    next_rx_par   = rx_par;
    next_rx_pend  = rx_pend;
    rx_copy       = 1'b0;
    rx_commit     = 1'b0;
    if (!rx_enable && rx_state != RX_DONE) begin
      next_rx_state = RX_IDLE;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          if (!rx_line) begin
            next_rx_state = RX_START;
            next_rx_cnt = 4'h0;
          end
        end
        RX_START: begin
          if (src_tick) begin
            if (rx_cnt[2:0] == asp_pkg::HALF_LAST) begin
              next_rx_cnt = 4'h0;
              next_rx_idx = 3'h0;
              next_rx_shift = 8'h00;
              next_rx_state = rx_line ? RX_IDLE : RX_DATA;
            end else begin
              next_rx_cnt = rx_cnt + 4'h1;
            end
          end
        end
        RX_DATA: begin
          if (src_tick) begin
            if (rx_cnt == asp_pkg::BIT_LAST) begin
              next_rx_cnt = 4'h0;
              next_rx_shift[rx_idx] = rx_line;
              if (rx_idx == last_idx) begin
                next_rx_state = (parity_mode == asp_pkg::PAR_NONE) ?
                                RX_STOP : RX_PAR;
              end else begin
                next_rx_idx = rx_idx + 3'h1;
              end
            end else begin
              next_rx_cnt = rx_cnt + 4'h1;
            end
          end
        end
        RX_PAR: begin
          if (src_tick) begin
            if (rx_cnt == asp_pkg::BIT_LAST) begin
              next_rx_cnt = 4'h0;
              next_rx_par = rx_line;
              next_rx_state = RX_STOP;
            end else begin
              next_rx_cnt = rx_cnt + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (src_tick) begin
            if (rx_cnt == asp_pkg::BIT_LAST) begin
              next_rx_cnt = 4'h0;
              rx_copy = 1'b1;
              next_rx_pend[asp_pkg::STAT_PE] = asp_pkg::asp_rx_par_err(
                rx_shift, char8, parity_mode, rx_par);
              next_rx_pend[asp_pkg::STAT_FE] = !rx_line;
              next_rx_pend[asp_pkg::STAT_OVE] = rx_unread;
              next_rx_state = RX_DONE;
            end else begin
              next_rx_cnt = rx_cnt + 4'h1;
            end
          end
        end
        RX_DONE: begin
          if (src_tick) begin
            rx_commit = rx_enable;
            next_rx_state = RX_IDLE;
          end
        end
        default: begin
          next_rx_state = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= 4'h0;
      rx_idx   <= 3'h0;
      rx_shift <= 8'h00;
      rx_par   <= 1'b0;
      rx_pend  <= 3'h0;
    end else begin
      rx_state <= next_rx_state;
      rx_cnt   <= next_rx_cnt;
      rx_idx   <= next_rx_idx;
      rx_shift <= next_rx_shift;
      rx_par   <= next_rx_par;
      rx_pend  <= next_rx_pend;
    end
  end

  // Registers and events. Hardware sets win over software clears.
  always_comb begin
    next_async_mode_control = async_mode_control;
    next_clocked_serial_mode_control = clocked_serial_mode_control;
    next_baud_gen_control = baud_gen_control;
    next_rx_error_status = rx_error_status;
    next_rx_buffer_reg = rx_buffer_reg;
    next_rx_unread = rx_unread;
    next_tx_req = tx_complete_request_flag;
    next_rx_irq = rx_commit;
    next_bus_rdata = bus_rdata;
    if (bus_wr) begin
      unique case (bus_addr)
        asp_pkg::ADDR_MODE: begin
          next_async_mode_control = bus_wdata & asp_pkg::MODE_MASK;
        end
        asp_pkg::ADDR_CLKD: begin
          next_clocked_serial_mode_control =
            bus_wdata & asp_pkg::CLKD_MASK;
        end
        asp_pkg::ADDR_BAUD: begin
          next_baud_gen_control = bus_wdata & asp_pkg::BAUD_MASK;
        end
        default: begin
        end
      endcase
    end
    if (bus_rd) begin
      unique case (bus_addr)
        asp_pkg::ADDR_MODE: next_bus_rdata = async_mode_control;
        asp_pkg::ADDR_STATUS: next_bus_rdata = rx_error_status;
        asp_pkg::ADDR_CLKD: next_bus_rdata = clocked_serial_mode_control;
        asp_pkg::ADDR_BAUD: next_bus_rdata = baud_gen_control;
        asp_pkg::ADDR_RXD: begin
          next_bus_rdata = rx_buffer_reg;
          next_rx_error_status = asp_pkg::STATUS_RST;
          next_rx_unread = 1'b0;
        end
        default: next_bus_rdata = 8'h00;
      endcase
    end
    if (tx_req_clear) begin
      next_tx_req = 1'b0;
    end
    if (tx_done) begin
      next_tx_req = 1'b1;
    end
    if (rx_copy) begin
      next_rx_buffer_reg = rx_shift;
      next_rx_unread = 1'b1;
    end
    if (rx_commit) begin
      next_rx_error_status = {5'h00, rx_pend};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      async_mode_control          <= asp_pkg::MODE_RST;
      clocked_serial_mode_control <= asp_pkg::CLKD_RST;
      baud_gen_control            <= asp_pkg::BAUD_RST;
      rx_error_status             <= asp_pkg::STATUS_RST;
      rx_buffer_reg               <= asp_pkg::RXBUF_RST;
      rx_unread                   <= 1'b0;
      tx_complete_request_flag    <= 1'b0;
      rx_complete_irq             <= 1'b0;
      bus_rdata                   <= 8'h00;
    end else begin
      async_mode_control          <= next_async_mode_control;
      clocked_serial_mode_control <= next_clocked_serial_mode_control;
      baud_gen_control            <= next_baud_gen_control;
      rx_error_status             <= next_rx_error_status;
      rx_buffer_reg               <= next_rx_buffer_reg;
      rx_unread                   <= next_rx_unread;
      tx_complete_request_flag    <= next_tx_req;
      rx_complete_irq             <= next_rx_irq;
      bus_rdata                   <= next_bus_rdata;
    end
  end

  assign tx_complete_irq = tx_done;
endmodule
`default_nettype wire

/* File: verif/asp_uart_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_uart_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // CPU memory port
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  // Serial pins
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  // Events
  input wire logic        tx_req_clear,
  input wire logic        tx_complete_irq,
  input wire logic        tx_complete_request_flag,
  input wire logic        rx_complete_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_rd(logic [15:0] a);
    bus_rd && bus_addr == a;
  endsequence
  sequence s_tx_end;
    serial_out_pin ##1 (!tx_complete_irq && tx_complete_request_flag);
  endsequence
  property p_idle_rst;
    $fell(srst) |-> serial_out_pin && !tx_complete_irq && !rx_complete_irq
      && !tx_complete_request_flag;
  endproperty
  property p_tx_end;
    tx_complete_irq |-> s_tx_end;
  endproperty
  property p_flag_clr;
    tx_req_clear && !tx_complete_irq && !$past(tx_complete_irq)
      |=> !tx_complete_request_flag;
  endproperty
  property p_rx_pulse;
    rx_complete_irq |=> !rx_complete_irq;
  endproperty
  property p_unmapped;
    bus_rd && (bus_addr < 16'hff70 || bus_addr > 16'hff75)
      |=> bus_rdata == 8'h00;
  endproperty
  property p_mode_mask;
    s_rd(asp_pkg::ADDR_MODE) |=> bus_rdata[1:0] == 2'h0;
  endproperty
  property p_clkd_mask;
    s_rd(asp_pkg::ADDR_CLKD) |=> (bus_rdata & ~asp_pkg::CLKD_MASK) == 8'h00;
  endproperty
  property p_status_mask;
    s_rd(asp_pkg::ADDR_STATUS) |=> bus_rdata[7:3] == 5'h00;
  endproperty
  property p_rdata_hold;
    !bus_rd |=> $stable(bus_rdata);
  endproperty
  a_idle_rst: assert property (p_idle_rst)
    else $error("line or events not idle after reset");
  a_tx_end: assert property (p_tx_end)
    else $error("transmit end not high, single pulse and flagged");
  a_flag_clr: assert property (p_flag_clr)
    else $error("request flag did not clear");
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive event longer than one cycle");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_mode_mask: assert property (p_mode_mask)
    else $error("mode low bits not zero");
  a_clkd_mask: assert property (p_clkd_mask)
    else $error("clocked mode reserved bits not zero");
  a_status_mask: assert property (p_status_mask)
    else $error("status upper bits not zero");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
endmodule
bind asp_uart asp_uart_checker asp_uart_checker_i (.core_clk, .srst,
  .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .serial_in_pin,
  .serial_out_pin, .tx_req_clear, .tx_complete_irq,
  .tx_complete_request_flag, .rx_complete_irq);
`default_nettype wire

/* File: verif/asp_remote.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_remote #(
  parameter int BIT = 32
) (
  // Clock
  input  wire logic core_clk,
  // Serial lines
  input  wire logic serial_out_pin,
  output var logic  serial_in_pin
);
  logic [11:0] cap;
  int          caps;
  initial begin
    serial_in_pin = 1'b1;
    cap = '1;
    caps = 0;
  end
  // Sampling at mid-bit keeps a tick of start skew harmless.
  always begin
    @(negedge serial_out_pin);
    repeat (BIT / 2) @(negedge core_clk);
    for (int i = 0; i < 12; i++) begin
      cap[i] = serial_out_pin;
      if (i < 11) repeat (BIT) @(negedge core_clk);
    end
    caps++;
  end
  // Bits go out first entry first; the line idles high afterwards.
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= bits[i];
      repeat (BIT) @(negedge core_clk);
    end
    serial_in_pin <= 1'b1;
    repeat (2 * BIT) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_asp_uart.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_asp_uart;
  // Baud select 0 gives a tick every 2 clocks, so a bit is 32 clocks.
  localparam int BIT = 32;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [7:0]  bus_wdata = 8'h00;
  logic [7:0]  bus_rdata;
  logic        serial_in_pin;
  logic        serial_out_pin;
  logic        tx_req_clear = 1'b0;
  logic        tx_complete_irq;
  logic        tx_complete_request_flag;
  logic        rx_complete_irq;
  logic [7:0]  rd_val;
  int          fail_count = 0;
  int          total_checks = 0;
  int          tx_irqs = 0;
  int          rx_irqs = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (tx_complete_irq === 1'b1) tx_irqs++;
    if (rx_complete_irq === 1'b1) rx_irqs++;
  end
  asp_uart asp_uart_i (.core_clk(core_clk), .srst(srst),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .tx_req_clear(tx_req_clear), .tx_complete_irq(tx_complete_irq),
    .tx_complete_request_flag(tx_complete_request_flag),
    .rx_complete_irq(rx_complete_irq));
  asp_remote #(.BIT(BIT)) asp_remote_i (.core_clk(core_clk),
    .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin));
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_v(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_n(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge core_clk);
    bus_wr = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge core_clk);
    bus_rd = 1'b0;
    @(negedge core_clk);
    rd_val = bus_rdata;
  endtask
  task automatic wait_irq(input int tx_t, input int rx_t);
    for (int n = 0; n < 20 * BIT && (tx_irqs < tx_t || rx_irqs < rx_t); n++)
      @(negedge core_clk);
  endtask
  function automatic logic [11:0] exp_tx(input logic [7:0] m,
                                         input logic [7:0] d);
    logic [11:0] v;
    logic [7:0]  dd;
    int          n;
    v = 12'hffe;
    n = m[3] ? 8 : 7;
    dd = m[3] ? d : {1'b0, d[6:0]};
    for (int i = 0; i < n; i++) v[1 + i] = dd[i];
    if (m[5:4] == asp_pkg::PAR_ODD) v[1 + n] = ~^dd;
    if (m[5:4] == asp_pkg::PAR_EVEN) v[1 + n] = ^dd;
    if (m[5:4] == asp_pkg::PAR_ZERO) v[1 + n] = 1'b0;
    return v;
  endfunction
  task automatic test_reset();
    logic [15:0] al [6];
    al = '{16'hff70, 16'hff71, 16'hff72, 16'hff73, 16'hff75, 16'hff76};
    foreach (al[i]) begin
      rd(al[i]);
      cmp_v({4'h0, rd_val}, 12'h000);
    end
  endtask
  task automatic test_masks();
    wr(asp_pkg::ADDR_MODE, 8'hff);
    rd(asp_pkg::ADDR_MODE);
    cmp_v({4'h0, rd_val}, 12'h0fc);
    wr(asp_pkg::ADDR_CLKD, 8'hff);
    rd(asp_pkg::ADDR_CLKD);
    cmp_v({4'h0, rd_val}, 12'h086);
    wr(asp_pkg::ADDR_CLKD, 8'h00);
    wr(asp_pkg::ADDR_MODE, 8'h00);
  endtask
  task automatic tx_case(input logic [7:0] m, input logic [7:0] d);
    int t0;
    int c0;
    t0 = tx_irqs;
    c0 = asp_remote_i.caps;
    wr(asp_pkg::ADDR_MODE, m);
    wr(asp_pkg::ADDR_TXD, d);
    wait_irq(t0 + 1, 0);
    for (int n = 0; n < 8 * BIT && asp_remote_i.caps == c0; n++)
      @(negedge core_clk);
    cmp_v(asp_remote_i.cap, exp_tx(m, d));
    cmp_n(tx_irqs, t0 + 1);
    cmp_v({11'h0, tx_complete_request_flag}, 12'h001);
    tx_req_clear = 1'b1;
    @(negedge core_clk);
    tx_req_clear = 1'b0;
    @(negedge core_clk);
    cmp_v({11'h0, tx_complete_request_flag}, 12'h000);
  endtask
  task automatic test_tx();
    tx_case(8'ha8, 8'h35);
    tx_case(8'hb8, 8'h35);
    tx_case(8'h98, 8'hff);
    tx_case(8'h88, 8'h81);
    tx_case(8'ha0, 8'hc3);
    tx_case(8'h8c, 8'h5a);
  endtask
  task automatic test_tx_refused();
    int t0;
    t0 = tx_irqs;
    wr(asp_pkg::ADDR_MODE, 8'h00);
    wr(asp_pkg::ADDR_TXD, 8'h00);
    repeat (12 * BIT) @(negedge core_clk);
    cmp_n(tx_irqs, t0);
    cmp_v({11'h0, serial_out_pin}, 12'h001);
  endtask
  // A frame cut by clearing transmit enable must leave the line idle and
  // the transmitter ready once software has followed the restart sequence.
  task automatic test_tx_abort();
    int t0;
    t0 = tx_irqs;
    wr(asp_pkg::ADDR_MODE, 8'h88);
    wr(asp_pkg::ADDR_TXD, 8'h00);
    repeat (3 * BIT) @(negedge core_clk);
    wr(asp_pkg::ADDR_MODE, 8'h08);
    cmp_v({11'h0, serial_out_pin}, 12'h001);
    wr(asp_pkg::ADDR_TXD, 8'hff);
    wr(asp_pkg::ADDR_MODE, 8'h88);
    repeat (12 * BIT) @(negedge core_clk);
    cmp_n(tx_irqs, t0);
    tx_case(8'h88, 8'h3c);
  endtask
  task automatic rx_case(input logic [7:0] m, input logic [11:0] f,
                         input int n, input logic [7:0] st,
                         input logic [7:0] d);
    int r0;
    r0 = rx_irqs;
    wr(asp_pkg::ADDR_MODE, m);
    asp_remote_i.send(f, n);
    wait_irq(0, r0 + 1);
    cmp_n(rx_irqs, r0 + 1);
    rd(asp_pkg::ADDR_STATUS);
    cmp_v({4'h0, rd_val}, {4'h0, st});
    rd(asp_pkg::ADDR_RXD);
    cmp_v({4'h0, rd_val}, {4'h0, d});
  endtask
  task automatic test_rx_frames();
    rx_case(8'h68, {3'b111, 8'h35, 1'b0}, 11, 8'h00, 8'h35);
    rx_case(8'h68, {3'b110, 8'h35, 1'b0}, 11, 8'h04, 8'h35);
    rx_case(8'h78, {3'b111, 8'h35, 1'b0}, 11, 8'h04, 8'h35);
    rx_case(8'h58, {3'b111, 8'h35, 1'b0}, 11, 8'h00, 8'h35);
    rx_case(8'h48, {3'b111, 8'h9c, 1'b0}, 10, 8'h00, 8'h9c);
    rx_case(8'h40, {4'hf, 7'h55, 1'b0}, 9, 8'h00, 8'h55);
    rx_case(8'h48, {3'b110, 8'ha6, 1'b0}, 10, 8'h02, 8'ha6);
  endtask
  task automatic test_rx_overrun();
    int r0;
    r0 = rx_irqs;
    asp_remote_i.send({3'b111, 8'h11, 1'b0}, 10);
    asp_remote_i.send({3'b111, 8'h22, 1'b0}, 10);
    wait_irq(0, r0 + 2);
    cmp_n(rx_irqs, r0 + 2);
    rd(asp_pkg::ADDR_STATUS);
    cmp_v({4'h0, rd_val}, 12'h001);
    rd(asp_pkg::ADDR_RXD);
    cmp_v({4'h0, rd_val}, 12'h022);
    rd(asp_pkg::ADDR_STATUS);
    cmp_v({4'h0, rd_val}, 12'h000);
  endtask
  task automatic test_rx_abort();
    int r0;
    r0 = rx_irqs;
    fork
      asp_remote_i.send({3'b111, 8'h5c, 1'b0}, 10);
      begin
        repeat (4 * BIT) @(negedge core_clk);
        wr(asp_pkg::ADDR_MODE, 8'h08);
      end
    join
    cmp_n(rx_irqs, r0);
    rd(asp_pkg::ADDR_STATUS);
    cmp_v({4'h0, rd_val}, 12'h000);
    rd(asp_pkg::ADDR_RXD);
    cmp_v({4'h0, rd_val}, 12'h022);
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    test_reset();
    test_masks();
    test_tx();
    test_tx_refused();
    test_tx_abort();
    test_rx_frames();
    test_rx_overrun();
    test_rx_abort();
    finish_test();
  end
  // The tests need about 8000 cycles; this leaves ample margin.
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
